/* verilog/i2cx_expander.sv */
// i2c slave port expander: three input ports, two output registers
`timescale 1ns/100ps

module i2cx_expander (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire i2cx_pkg::i2cx_inputs_t inLines,
  input wire logic [i2cx_pkg::SEL_W-1:0] regSel,
  output i2cx_pkg::i2cx_outputs_t outLines,
  output logic busBusy
);

  // ---------------------------------------------------------------
  // system clock side: bus condition detection
  // ---------------------------------------------------------------
  logic sclMeta_r, sclSync_r, sdaMeta_r, sdaSync_r, sdaPrev_r;
  logic busy_r, busy_nxt;
  logic frameRst_r, frameRst_nxt;
  logic [3:0] rstCnt_r, rstCnt_nxt;
  logic sdaOut_r;
  logic startSeen, stopSeen;
  logic linkRstN;

  // sda edges are judged only on synchronised copies
  assign startSeen = sclSync_r & sdaPrev_r & ~sdaSync_r;
  assign stopSeen = sclSync_r & ~sdaPrev_r & sdaSync_r;

  // busy flag and a short reset pulse into the link domain
  // start is tested first; both cannot arrive together, since sda
  // moves only once per synchronised sample
  always_comb begin
    busy_nxt = busy_r;
    rstCnt_nxt = rstCnt_r;
    frameRst_nxt = 1'b0;
    if (startSeen) begin
      busy_nxt = 1'b1;
    end else if (stopSeen) begin
      busy_nxt = 1'b0;
    end
    if (startSeen || stopSeen) begin
      rstCnt_nxt = i2cx_pkg::FRAME_RST_LOAD;
    end else if (rstCnt_r != 4'h0) begin
      rstCnt_nxt = rstCnt_r - 4'h1;
    end
    if (rstCnt_nxt != 4'h0) begin
      frameRst_nxt = 1'b1;
    end
  end

  // synchronisers and condition state
  // reset to the idle level, so no false edge follows a reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclMeta_r <= 1'b1;
      sclSync_r <= 1'b1;
      sdaMeta_r <= 1'b1;
      sdaSync_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      busy_r <= 1'b0;
      rstCnt_r <= 4'h0;
      frameRst_r <= 1'b0;
      sdaOut_r <= 1'b0;
    end else begin
      sclMeta_r <= sclClk;
      sclSync_r <= sclMeta_r;
      sdaMeta_r <= sdaIn;
      sdaSync_r <= sdaMeta_r;
      sdaPrev_r <= sdaSync_r;
      busy_r <= busy_nxt;
      rstCnt_r <= rstCnt_nxt;
      frameRst_r <= frameRst_nxt;
      sdaOut_r <= 1'b0; // open drain: only the enable moves
    end
  end

  // the link logic is re-initialised by start and stop; the pulse
  // lands while scl is high, well away from any scl edge
  // limitation: the master must keep scl high for about 40 ns around
  // each start and stop, or the pulse can swallow a clock edge
  // trade-off: a clocked detector costs this hold time but avoids an
  // asynchronous latch on sda
  assign linkRstN = resetn & ~frameRst_r;

  // ---------------------------------------------------------------
  // link side: input line synchronisers on scl falling edges
  // ---------------------------------------------------------------
  i2cx_pkg::i2cx_inputs_t inMeta_r, inSync_r;
  logic [i2cx_pkg::SEL_W-1:0] selMeta_r, selSync_r;

  // input and select pins reach the link logic only through two flops; scl only
  // runs inside frames, so the address byte fills this pipe
  // direct bits are therefore two scl falls old when they go out
  always_ff @(negedge sclClk or negedge resetn) begin
    if (!resetn) begin
      inMeta_r <= '0;
      inSync_r <= '0;
      selMeta_r <= '0;
      selSync_r <= '0;
    end else begin
      inMeta_r <= inLines;
      inSync_r <= inMeta_r;
      selMeta_r <= regSel;
      selSync_r <= selMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // link side: sampling on scl rising edges
  // ---------------------------------------------------------------
  i2cx_pkg::i2cx_lstate_t st_r, st_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [6:0] shift_r, shift_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic rd_r, rd_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [15:0] capt_r, capt_nxt;
  logic [7:0] rxByte;
  logic [2:0] hitPort;
  logic [7:0] txMux;
  logic wrEn;
  i2cx_pkg::i2cx_outputs_t outs_r, outs_nxt;

  // address compare against the five fixed port addresses
  // the five addresses must differ; with an overlap the last compare wins
  function automatic logic [2:0] portOf(input logic [6:0] a);
    logic [2:0] p;
    p = i2cx_pkg::PORT_NONE;
    if (a == i2cx_pkg::ADDR_IN0) p = i2cx_pkg::PORT_IN0;
    if (a == i2cx_pkg::ADDR_IN1) p = i2cx_pkg::PORT_IN1;
    if (a == i2cx_pkg::ADDR_IN2) p = i2cx_pkg::PORT_IN2;
    if (a == i2cx_pkg::ADDR_OUT0) p = i2cx_pkg::PORT_OUT0;
    if (a == i2cx_pkg::ADDR_OUT1) p = i2cx_pkg::PORT_OUT1;
    return p;
  endfunction

  // the last bit of a byte is taken straight from the pin at its rise
  assign rxByte = {shift_r, sdaIn};
  assign hitPort = portOf(shift_r);

  // registered bits take the capture made at the address byte, direct
  // bits the live synchronised lines; shared by both selectable ports
  function automatic logic [7:0] mergeBits(input logic [7:0] capt,
                                           input logic [7:0] live,
                                           input logic [7:0] sel);
    return (capt & sel) | (live & ~sel);
  endfunction

  // byte to transmit; the output ports read back their registers, and
  // an unmatched port never reaches a read slot
  always_comb begin
    unique case (sel_r)
      i2cx_pkg::PORT_IN0: begin
        txMux = mergeBits(capt_r[7:0], inSync_r.in0,
                          selSync_r[7:0]);
      end
      i2cx_pkg::PORT_IN1: begin
        txMux = mergeBits(capt_r[15:8], inSync_r.in1,
                          selSync_r[15:8]);
      end
      i2cx_pkg::PORT_IN2: txMux = inSync_r.in2;
      i2cx_pkg::PORT_OUT0: txMux = outs_r.out0;
      default: txMux = outs_r.out1;
    endcase
  end

  // protocol sequencer, one step per scl rising edge
  //   addr   : shifting in address and direction
  //   ack    : device holds sda low for the ninth pulse
  //   wdata  : shifting a byte bound for an output register
  //   rdata  : sending a port byte, msb first
  //   rack   : sda released, master answers
  //   ignore : parked until the next start or stop
  // the counter wraps from seven to zero by itself, so only the
  // acknowledge slots force it back
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 3'h1;
    shift_nxt = rxByte[6:0];
    sel_nxt = sel_r;
    rd_nxt = rd_r;
    tx_nxt = tx_r;
    capt_nxt = capt_r;
    wrEn = 1'b0;
    unique case (st_r)
      i2cx_pkg::LS_ADDR: begin
        if (cnt_r == i2cx_pkg::LAST_BIT) begin
          sel_nxt = hitPort;
          rd_nxt = sdaIn;
          capt_nxt = {inSync_r.in1, inSync_r.in0};
          // writes to an input port are not ours to accept
          if (hitPort == i2cx_pkg::PORT_NONE ||
              (sdaIn != i2cx_pkg::DIR_READ &&
               hitPort < i2cx_pkg::PORT_OUT0)) begin
            st_nxt = i2cx_pkg::LS_IGNORE;
          end else begin
            st_nxt = i2cx_pkg::LS_ACK;
          end
        end
      end
      i2cx_pkg::LS_ACK: begin
        cnt_nxt = 3'h0;
        if (rd_r) begin
          st_nxt = i2cx_pkg::LS_RDATA;
          tx_nxt = txMux;
        end else begin
          st_nxt = i2cx_pkg::LS_WDATA;
        end
      end
      i2cx_pkg::LS_WDATA: begin
        if (cnt_r == i2cx_pkg::LAST_BIT) begin
          wrEn = 1'b1;
          st_nxt = i2cx_pkg::LS_ACK;
        end
      end
      i2cx_pkg::LS_RDATA: begin
        if (cnt_r == i2cx_pkg::LAST_BIT) begin
          st_nxt = i2cx_pkg::LS_RACK;
        end
      end
      i2cx_pkg::LS_RACK: begin
        cnt_nxt = 3'h0;
        if (!sdaIn) begin
          st_nxt = i2cx_pkg::LS_RDATA;
          tx_nxt = txMux;
        end else begin
          st_nxt = i2cx_pkg::LS_IGNORE;
        end
      end
      i2cx_pkg::LS_IGNORE: begin
        cnt_nxt = cnt_r; // held until start or stop
      end
      default: st_nxt = i2cx_pkg::LS_IGNORE;
    endcase
  end

  // sequencer state, cleared by every start and stop
  always_ff @(posedge sclClk or negedge linkRstN) begin
    if (!linkRstN) begin
      st_r <= i2cx_pkg::LS_ADDR;
      cnt_r <= 3'h0;
      shift_r <= 7'h00;
      sel_r <= i2cx_pkg::PORT_NONE;
      rd_r <= 1'b0;
      tx_r <= 8'h00;
      capt_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      sel_r <= sel_nxt;
      rd_r <= rd_nxt;
      tx_r <= tx_nxt;
      capt_r <= capt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // output registers, untouched by bus conditions
  // ---------------------------------------------------------------
  always_comb begin
    outs_nxt = outs_r;
    if (wrEn && sel_r == i2cx_pkg::PORT_OUT0) begin
      outs_nxt.out0 = rxByte;
    end
    if (wrEn && sel_r == i2cx_pkg::PORT_OUT1) begin
      outs_nxt.out1 = rxByte;
    end
  end

  // only the system reset clears them; frame resets must not
  // a byte cut short by a stop never raises wrEn, so the register
  // keeps its old value
  always_ff @(posedge sclClk or negedge resetn) begin
    if (!resetn) begin
      outs_r <= {i2cx_pkg::OUT_RESET, i2cx_pkg::OUT_RESET};
    end else begin
      outs_r <= outs_nxt;
    end
  end

  // ---------------------------------------------------------------
  // link side: sda drive on scl falling edges
  // ---------------------------------------------------------------
  logic sdaOe_r, sdaOe_nxt;

  // ack low in the ack slot, data bits msb first, released elsewhere
  // the enable is the only moving part; sdaOut stays low so the pin
  // can never drive a high level onto the bus
  always_comb begin
    sdaOe_nxt = 1'b0;
    if (st_r == i2cx_pkg::LS_ACK) begin
      sdaOe_nxt = 1'b1;
    end else if (st_r == i2cx_pkg::LS_RDATA) begin
      sdaOe_nxt = ~tx_r[i2cx_pkg::LAST_BIT - cnt_r];
    end
  end

  // falling edge only, so sda never moves while scl is high
  always_ff @(negedge sclClk or negedge linkRstN) begin
    if (!linkRstN) begin
      sdaOe_r <= 1'b0;
    end else begin
      sdaOe_r <= sdaOe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // top outputs
  // ---------------------------------------------------------------
  // every output below comes straight from a flop
  assign sdaOe = sdaOe_r;
  assign sdaOut = sdaOut_r;
  assign outLines = outs_r;
  assign busBusy = busy_r;

endmodule

/* verilog/i2cx_pkg.sv */
// shared constants, states and carriers of the i2c port expander
package i2cx_pkg;

  // ---------------------------------------------------------------
  // port addresses, fixed at build time
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_IN0 = 7'h20;
  localparam logic [6:0] ADDR_IN1 = 7'h21;
  localparam logic [6:0] ADDR_IN2 = 7'h22;
  localparam logic [6:0] ADDR_OUT0 = 7'h23;
  localparam logic [6:0] ADDR_OUT1 = 7'h24;

  // port index codes
  localparam logic [2:0] PORT_IN0 = 3'h0;
  localparam logic [2:0] PORT_IN1 = 3'h1;
  localparam logic [2:0] PORT_IN2 = 3'h2;
  localparam logic [2:0] PORT_OUT0 = 3'h3;
  localparam logic [2:0] PORT_OUT1 = 3'h4;
  localparam logic [2:0] PORT_NONE = 3'h7;

  // ---------------------------------------------------------------
  // widths, reset values, bit positions
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int SEL_W = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic DIR_READ = 1'b1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int FRAME_RST_NS = 20;
  localparam int FRAME_RST_CYC =
    (FRAME_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] FRAME_RST_LOAD = 4'(FRAME_RST_CYC);

  // ---------------------------------------------------------------
  // link states and carriers
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    LS_ADDR, LS_ACK, LS_WDATA, LS_RDATA, LS_RACK, LS_IGNORE
  } i2cx_lstate_t;

  typedef struct packed {
    logic [7:0] in2;
    logic [7:0] in1;
    logic [7:0] in0;
  } i2cx_inputs_t;

  typedef struct packed {
    logic [7:0] out1;
    logic [7:0] out0;
  } i2cx_outputs_t;

endpackage

/* tb/i2cx_checker.sv */
// assertions on the i2c port expander ports
`timescale 1ns/100ps
module i2cx_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sclClk,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire i2cx_pkg::i2cx_inputs_t inLines,
  input wire logic [i2cx_pkg::SEL_W-1:0] regSel,
  input wire i2cx_pkg::i2cx_outputs_t outLines,
  input wire logic busBusy
);
  // ---------------------------------------------------------------
  // bus checks, all sampled by the system clock
  // ---------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_oe_scl_low: assert property ($changed(sdaOe) |-> !sclClk)
    else $error("sda drive moved while scl high");
  chk_oe_stable: assert property (
    $rose(sclClk) |-> $stable(sdaOe) [*4])
    else $error("sda drive unstable in scl high phase");
  chk_busy_start: assert property (
    $fell(sdaIn) && sclClk && $past(sclClk) |-> ##[1:8] busBusy)
    else $error("start not seen");
  chk_busy_stop: assert property (
    $rose(sdaIn) && sclClk && $past(sclClk) |-> ##[1:8] !busBusy)
    else $error("stop not seen");
  chk_idle_quiet: assert property (!busBusy |-> !sdaOe)
    else $error("sda pulled on idle bus");
  chk_out_hold: assert property ($changed(outLines) |-> busBusy)
    else $error("output register moved outside a transfer");
  chk_out_scl: assert property ($changed(outLines) |-> sclClk)
    else $error("output register moved while scl low");
  chk_ack_hold: assert property (
    $rose(sdaOe) |-> sdaOe throughout (##[1:20] sclClk))
    else $error("sda released before scl high");
endmodule

bind i2cx_expander i2cx_checker i2cx_checker_inst (
  .clk_sys(clk_sys), .resetn(resetn), .sclClk(sclClk),
  .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .inLines(inLines), .regSel(regSel), .outLines(outLines),
  .busBusy(busBusy)
);

/* tb/i2cx_master.sv */
// behavioural i2c bus master driving the expander link
`timescale 1ns/100ps
module i2cx_master (
  input wire logic sdaWire,
  output logic sclClk,
  output logic sdaLow
);
  // ---------------------------------------------------------------
  // link idle: scl stands high, sda released
  // ---------------------------------------------------------------
  initial begin
    sclClk = 1'b1;
    sdaLow = 1'b0;
  end

  // one bit per 48 ns scl period, sda moved mid low phase
  task automatic put_bit(input logic b, output logic r);
    sdaLow = !b;
    #12;
    sclClk = 1'b1;
    #20;
    r = sdaWire;
    #4;
    sclClk = 1'b0;
    #12;
  endtask

  // long scl high around start and stop for the frame reset
  task automatic start_cond;
    sdaLow = 1'b0;
    #12;
    sclClk = 1'b1;
    #100;
    sdaLow = 1'b1;
    #100;
    sclClk = 1'b0;
    #12;
  endtask

  task automatic stop_cond;
    sdaLow = 1'b1;
    #12;
    sclClk = 1'b1;
    #100;
    sdaLow = 1'b0;
    #100;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], r);
    end
    put_bit(1'b1, r);
    ack = !r;
  endtask

  task automatic get_byte(input logic more, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      b[i] = r;
    end
    put_bit(!more, r);
  endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the i2c port expander
`timescale 1ns/100ps
module tb;
  logic clk_sys;
  logic resetn;
  logic sclClk;
  logic sdaLow;
  logic sdaOut;
  logic sdaOe;
  logic sdaWire;
  logic busBusy;
  logic [15:0] regSel;
  i2cx_pkg::i2cx_inputs_t inLines;
  i2cx_pkg::i2cx_outputs_t outLines;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;
  logic ack;
  logic [7:0] rd;

  // open-drain wire with pull-up: low when any party pulls
  assign sdaWire = !(sdaLow || (sdaOe && !sdaOut));

  i2cx_expander i2cx_expander_inst (
    .clk_sys(clk_sys), .resetn(resetn), .sclClk(sclClk),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .inLines(inLines), .regSel(regSel), .outLines(outLines),
    .busBusy(busBusy)
  );
  i2cx_master i2cx_master_inst (
    .sdaWire(sdaWire), .sclClk(sclClk), .sdaLow(sdaLow)
  );

  // ---------------------------------------------------------------
  // clock, hang guard, compare and closing report
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = !clk_sys;
  end

  // whole run needs about 2800 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // short hands for the master's frame and byte steps
  task automatic go;
    i2cx_master_inst.start_cond();
    check({15'h0, busBusy}, 16'h0001);
  endtask

  task automatic halt;
    i2cx_master_inst.stop_cond();
    check({15'h0, busBusy}, 16'h0000);
    check({15'h0, sdaOut}, 16'h0000);
  endtask

  task automatic sb(input logic [7:0] b, input logic e);
    i2cx_master_inst.send_byte(b, ack);
    check({15'h0, ack}, {15'h0, e});
  endtask

  task automatic gb(input logic more, input logic [7:0] e);
    i2cx_master_inst.get_byte(more, rd);
    check({8'h0, rd}, {8'h0, e});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_write;
    go();
    sb({i2cx_pkg::ADDR_OUT0, 1'b0}, 1'b1);
    sb(8'ha5, 1'b1);
    sb(8'h3c, 1'b1);
    go();
    sb({i2cx_pkg::ADDR_OUT1, 1'b0}, 1'b1);
    sb(8'h5a, 1'b1);
    halt();
    check(outLines, 16'h5a3c);
    go();
    sb({i2cx_pkg::ADDR_OUT1, 1'b1}, 1'b1);
    gb(1'b0, 8'h5a);
    halt();
  endtask

  // each input port read twice, master nacks the second
  task automatic t_read;
    logic [7:0] v;
    for (int p = 0; p < 3; p++) begin
      v = inLines[p*8 +: 8];
      go();
      sb({7'(i2cx_pkg::ADDR_IN0 + p), 1'b1}, 1'b1);
      gb(1'b1, v);
      gb(1'b0, v);
      check({15'h0, sdaOe}, 16'h0);
      halt();
    end
  endtask

  // registered bits keep the address-phase snapshot, in2 stays live
  task automatic t_regd;
    @(posedge clk_sys);
    regSel <= 16'hffff;
    go();
    sb({i2cx_pkg::ADDR_IN1, 1'b1}, 1'b1);
    @(posedge clk_sys);
    inLines <= 24'h0f00e1;
    gb(1'b1, 8'hc3);
    gb(1'b0, 8'hc3);
    go();
    sb({i2cx_pkg::ADDR_IN2, 1'b1}, 1'b1);
    gb(1'b0, 8'h0f);
    halt();
  endtask

  // unknown address and write to an input port are both ignored
  task automatic t_miss;
    go();
    sb(8'h60, 1'b0);
    sb(8'h00, 1'b0);
    go();
    sb({i2cx_pkg::ADDR_IN0, 1'b0}, 1'b0);
    halt();
    check(outLines, 16'h5a3c);
  endtask

  initial begin
    resetn = 1'b0;
    regSel = 16'h0;
    inLines = 24'h96c3e1;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check(outLines, {2{i2cx_pkg::OUT_RESET}});
    t_write();
    t_read();
    t_regd();
    t_miss();
    wrap_up();
  end
endmodule
